// *** hdl/plt_pkg.sv ***
// Purpose: shared constants and types for the logic lookup tables
// Assumes: byte wide register port, mode fields supplied by the mode registers
// Notes: offsets, reset values, field positions and line numbers are the numbers used by the tables
`default_nettype none
package plt_pkg;

	// register offsets and reset values
	localparam logic [7:0] OFS_A_TWO_INPUT   = 8'h23;
	localparam logic [7:0] OFS_B_THREE_INPUT = 8'h24;
	localparam logic [7:0] RST_A_TWO_INPUT   = 8'h00;
	localparam logic [7:0] RST_B_THREE_INPUT = 8'h00;

	// field positions inside the bank a two input table
	localparam int A_HI_FIELD_LSB = 4;
	localparam int A_LO_FIELD_LSB = 0;

	// decoded line numbers and their selector fields
	localparam int LINE_A_HI_OUT = 6;
	localparam int LINE_A_HI_SEL = 4;
	localparam int LINE_A_LO_OUT = 2;
	localparam int LINE_A_LO_SEL = 0;
	localparam int LINE_B_HI_OUT = 15;
	localparam int LINE_B_HI_SEL = 12;

	// nibble logic mode encodings
	typedef enum logic [1:0] {
		MODE_GPIO       = 2'h0,
		MODE_TWO_TO_ONE = 2'h1,
		MODE_THREE_TO_1 = 2'h2,
		MODE_THREE_TO_2 = 2'h3
	} plt_mode_t;

	// register port request
	typedef struct packed {
		logic       wr_en;
		logic [7:0] addr;
		logic [7:0] wdata;
	} plt_reg_req_t;

	// per-line pin drive
	typedef struct packed {
		logic [15:0] out;
		logic [15:0] oe_n;
	} plt_pin_drive_t;

endpackage
`default_nettype wire

// *** hdl/plt_table_select.sv ***
// Purpose: picks one truth table bit from a selector value
// Assumes: table width is two to the power of the selector width
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
module plt_table_select #(
	parameter int SEL_W = 2
) (
	input  wire logic [(1<<SEL_W)-1:0] table_i,
	input  wire logic [SEL_W-1:0]      sel_i,
	output logic                       bit_o
);

	// index the table by the selector value
	assign bit_o = table_i[sel_i];

endmodule
`default_nettype wire

// *** hdl/plt_lookup_tables.sv ***
// Purpose: lookup table stage of the programmable logic for lines 6, 2 and 15
// Assumes: mode fields come from the mode registers; pins sampled synchronously
// Notes: decoded outputs follow their selectors with one cycle of latency
`timescale 1ns/1ps
`default_nettype none

module plt_lookup_tables (
	input  wire logic                    clk_i,
	input  wire logic                    resetn_i,
	input  wire plt_pkg::plt_reg_req_t   reg_req_i,
	output logic [7:0]                   reg_rdata_o,
	input  wire logic [1:0]              bank_a_upper_nibble_logic_mode_i,
	input  wire logic [1:0]              bank_a_lower_nibble_logic_mode_i,
	input  wire logic [1:0]              bank_b_upper_nibble_logic_mode_i,
	input  wire logic [15:0]             io_in_i,
	input  wire plt_pkg::plt_pin_drive_t gpio_drive_i,
	output plt_pkg::plt_pin_drive_t      io_drive_o
);

	logic [7:0]              bank_a_two_input_truth_table;
	logic [7:0]              bank_b_three_input_truth_table;
	logic                    a_hi_bit;
	logic                    a_lo_bit;
	logic                    b_hi_bit;
	logic                    a_hi_on;
	logic                    a_lo_on;
	logic                    b_hi_on;
	plt_pkg::plt_pin_drive_t next_drive;

	// mode decode for each nibble
	assign a_hi_on = bank_a_upper_nibble_logic_mode_i == plt_pkg::MODE_TWO_TO_ONE;
	assign a_lo_on = bank_a_lower_nibble_logic_mode_i == plt_pkg::MODE_TWO_TO_ONE;
	assign b_hi_on = bank_b_upper_nibble_logic_mode_i == plt_pkg::MODE_THREE_TO_1;

	// bank a truth table register
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			bank_a_two_input_truth_table <= plt_pkg::RST_A_TWO_INPUT;
		end else if (reg_req_i.wr_en && reg_req_i.addr == plt_pkg::OFS_A_TWO_INPUT) begin
			bank_a_two_input_truth_table <= reg_req_i.wdata;
		end
	end

	// bank b truth table register
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			bank_b_three_input_truth_table <= plt_pkg::RST_B_THREE_INPUT;
		end else if (reg_req_i.wr_en && reg_req_i.addr == plt_pkg::OFS_B_THREE_INPUT) begin
			bank_b_three_input_truth_table <= reg_req_i.wdata;
		end
	end

	// registered read back, unmapped offsets read zero
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			reg_rdata_o <= 8'h00;
		end else begin
			unique case (reg_req_i.addr)
				plt_pkg::OFS_A_TWO_INPUT:   reg_rdata_o <= bank_a_two_input_truth_table;
				plt_pkg::OFS_B_THREE_INPUT: reg_rdata_o <= bank_b_three_input_truth_table;
				default:                    reg_rdata_o <= 8'h00;
			endcase
		end
	end

	// line 6 lookup from the upper half of the bank a table
	plt_table_select #(
		.SEL_W(2)
	) u_sel_a_hi (
		.table_i(bank_a_two_input_truth_table[plt_pkg::A_HI_FIELD_LSB +: 4]),
		.sel_i  (io_in_i[plt_pkg::LINE_A_HI_SEL +: 2]),
		.bit_o  (a_hi_bit)
	);

	// line 2 lookup from the lower half of the bank a table
	plt_table_select #(
		.SEL_W(2)
	) u_sel_a_lo (
		.table_i(bank_a_two_input_truth_table[plt_pkg::A_LO_FIELD_LSB +: 4]),
		.sel_i  (io_in_i[plt_pkg::LINE_A_LO_SEL +: 2]),
		.bit_o  (a_lo_bit)
	);

	// line 15 lookup from the bank b table
	plt_table_select #(
		.SEL_W(3)
	) u_sel_b_hi (
		.table_i(bank_b_three_input_truth_table),
		.sel_i  (io_in_i[plt_pkg::LINE_B_HI_SEL +: 3]),
		.bit_o  (b_hi_bit)
	);

	// pin drive: gpio by default, decoded lines override when enabled
	always_comb begin
		next_drive = gpio_drive_i;
		if (a_hi_on) begin
			next_drive.out[plt_pkg::LINE_A_HI_OUT]  = a_hi_bit;
			next_drive.oe_n[plt_pkg::LINE_A_HI_OUT] = 1'b0;
		end
		if (a_lo_on) begin
			next_drive.out[plt_pkg::LINE_A_LO_OUT]  = a_lo_bit;
			next_drive.oe_n[plt_pkg::LINE_A_LO_OUT] = 1'b0;
		end
		if (b_hi_on) begin
			next_drive.out[plt_pkg::LINE_B_HI_OUT]  = b_hi_bit;
			next_drive.oe_n[plt_pkg::LINE_B_HI_OUT] = 1'b0;
		end
	end

	// output stage, one cycle behind selectors and modes
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			io_drive_o <= '{out: 16'h0000, oe_n: 16'hffff};
		end else begin
			io_drive_o <= next_drive;
		end
	end

	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);

	// pin drive checks, started on an edge so the reset value is never compared
	line6_decode_a: assert property (
		a_hi_on |=> io_drive_o.out[6] ==
			$past(bank_a_two_input_truth_table[4 + io_in_i[5:4]]) && !io_drive_o.oe_n[6])
		else $error("line 6 does not match its table bit");

	line6_gate_a: assert property (
		!a_hi_on |=> io_drive_o.out[6] == $past(gpio_drive_i.out[6]) &&
			io_drive_o.oe_n[6] == $past(gpio_drive_i.oe_n[6]))
		else $error("line 6 changed by table while mode not two-to-one");

	line2_decode_a: assert property (
		a_lo_on |=> io_drive_o.out[2] ==
			$past(bank_a_two_input_truth_table[io_in_i[1:0]]) && !io_drive_o.oe_n[2])
		else $error("line 2 does not match its table bit");

	line2_gate_a: assert property (
		!a_lo_on |=> io_drive_o.out[2] == $past(gpio_drive_i.out[2]) &&
			io_drive_o.oe_n[2] == $past(gpio_drive_i.oe_n[2]))
		else $error("line 2 changed by table while mode not two-to-one");

	line15_decode_a: assert property (
		b_hi_on |=> io_drive_o.out[15] ==
			$past(bank_b_three_input_truth_table[io_in_i[14:12]]) && !io_drive_o.oe_n[15])
		else $error("line 15 does not match its table bit");

	line15_gate_a: assert property (
		!b_hi_on |=> io_drive_o.out[15] == $past(gpio_drive_i.out[15]) &&
			io_drive_o.oe_n[15] == $past(gpio_drive_i.oe_n[15]))
		else $error("line 15 changed by table while mode not three-to-one");

	mode01_drive_a: assert property (
		bank_a_upper_nibble_logic_mode_i == 2'h1 ##1 1'b1 |-> !io_drive_o.oe_n[6])
		else $error("mode 01 did not take over line 6");

	mode01_low_a: assert property (
		bank_a_lower_nibble_logic_mode_i == 2'h1 |=> !io_drive_o.oe_n[2])
		else $error("mode 01 did not take over line 2");

	gpio_passthru_a: assert property (
		bank_a_lower_nibble_logic_mode_i == 2'h0 && bank_a_upper_nibble_logic_mode_i == 2'h0
			|=> io_drive_o.out[7:0] == $past(gpio_drive_i.out[7:0]) &&
			io_drive_o.oe_n[7:0] == $past(gpio_drive_i.oe_n[7:0]))
		else $error("gpio mode does not pass bank a lines through");

	gpio_bank_b_a: assert property (
		bank_b_upper_nibble_logic_mode_i == 2'h0 |=> io_drive_o.out[15:12] ==
			$past(gpio_drive_i.out[15:12]) && io_drive_o.oe_n[15:12] == $past(gpio_drive_i.oe_n[15:12]))
		else $error("gpio mode does not pass bank b upper lines through");

	other_lines_a: assert property (
		1'b1 |=> (io_drive_o.out & 16'h7fbb) == ($past(gpio_drive_i.out) & 16'h7fbb) &&
			(io_drive_o.oe_n & 16'h7fbb) == ($past(gpio_drive_i.oe_n) & 16'h7fbb))
		else $error("a line without a table was not left to gpio");

	follow_sel_a: assert property (
		a_lo_on && $stable(bank_a_two_input_truth_table) && !reg_req_i.wr_en
			##1 a_lo_on |=> io_drive_o.out[2] ==
			$past(bank_a_two_input_truth_table[io_in_i[1:0]]))
		else $error("line 2 did not follow its selectors within one cycle");

	follow_hi_a: assert property (
		b_hi_on && $stable(bank_b_three_input_truth_table) && !reg_req_i.wr_en
			##1 b_hi_on |=> io_drive_o.out[15] ==
			$past(bank_b_three_input_truth_table[io_in_i[14:12]]))
		else $error("line 15 did not follow its selectors within one cycle");

	// register port checks
	readback_a: assert property (
		reg_req_i.addr == 8'h23 |=> reg_rdata_o == $past(bank_a_two_input_truth_table))
		else $error("bank a table read back wrong");

	readback_b_a: assert property (
		reg_req_i.addr == 8'h24 |=> reg_rdata_o == $past(bank_b_three_input_truth_table))
		else $error("bank b table read back wrong");

	unmapped_read_a: assert property (
		reg_req_i.addr != plt_pkg::OFS_A_TWO_INPUT &&
			reg_req_i.addr != plt_pkg::OFS_B_THREE_INPUT |=> reg_rdata_o == 8'h00)
		else $error("unmapped offset did not read zero");

	table_a_write_a: assert property (
		reg_req_i.wr_en && reg_req_i.addr == plt_pkg::OFS_A_TWO_INPUT
			|=> bank_a_two_input_truth_table == $past(reg_req_i.wdata))
		else $error("bank a table write did not land");

	table_b_write_a: assert property (
		reg_req_i.wr_en && reg_req_i.addr == plt_pkg::OFS_B_THREE_INPUT
			|=> bank_b_three_input_truth_table == $past(reg_req_i.wdata))
		else $error("bank b table write did not land");

	stray_write_a: assert property (
		reg_req_i.wr_en && reg_req_i.addr != plt_pkg::OFS_A_TWO_INPUT &&
			reg_req_i.addr != plt_pkg::OFS_B_THREE_INPUT |=> $stable(bank_a_two_input_truth_table) &&
			$stable(bank_b_three_input_truth_table))
		else $error("write to an unmapped offset changed a table");

endmodule
`default_nettype wire

// *** verification/plt_io_model.sv ***
// Purpose: pin level model of the circuitry on the expander lines
// Assumes: bench says which lines the far side drives and with what
// Notes: a released line shows the far side value where the far side drives, else its inverse
`timescale 1ns/1ps
`default_nettype none
module plt_io_model (
	input  wire plt_pkg::plt_pin_drive_t dev_i,
	input  wire logic [15:0]             ext_val_i,
	input  wire logic [15:0]             ext_en_i,
	output logic [15:0]                  pin_o
);
	// resolve each wire; both sides driving shows as unknown
	always_comb begin
		for (int k = 0; k < 16; k++) begin
			pin_o[k] = !dev_i.oe_n[k] ? (ext_en_i[k] ? 1'bx : dev_i.out[k])
				: (ext_en_i[k] ? ext_val_i[k] : ~ext_val_i[k]);
		end
	end
endmodule
`default_nettype wire

// *** verification/testbench.sv ***
// Purpose: self checking bench for the logic lookup tables
// Assumes: inputs change at the falling edge, outputs one cycle late
// Notes: far side drives the selector lines 14:12, 5:4 and 1:0
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam logic [7:0] TAB_A = 8'h1b;
	localparam logic [7:0] TAB_B = 8'h2d;
	logic                    clk_i     = 1'b0;
	logic                    resetn_i  = 1'b0;
	plt_pkg::plt_reg_req_t   reg_req_i = '0;
	plt_pkg::plt_pin_drive_t gpio      = {16'h8c44, 16'hf077};
	plt_pkg::plt_pin_drive_t io_drive_o;
	logic [7:0]              reg_rdata_o;
	logic [1:0]              mode_ahi  = 2'h0;
	logic [1:0]              mode_alo  = 2'h0;
	logic [1:0]              mode_bhi  = 2'h0;
	logic [15:0]             ext_val   = 16'h0000;
	logic [15:0]             io_in;
	int                      errors    = 0;
	int                      checks    = 0;
	// free running clock
	always #10 clk_i = ~clk_i;
	plt_lookup_tables DUT (.clk_i(clk_i), .resetn_i(resetn_i), .reg_req_i(reg_req_i),
		.reg_rdata_o(reg_rdata_o), .bank_a_upper_nibble_logic_mode_i(mode_ahi),
		.bank_a_lower_nibble_logic_mode_i(mode_alo),
		.bank_b_upper_nibble_logic_mode_i(mode_bhi), .io_in_i(io_in),
		.gpio_drive_i(gpio), .io_drive_o(io_drive_o));
	plt_io_model pins (.dev_i(io_drive_o), .ext_val_i(ext_val), .ext_en_i(16'h7033),
		.pin_o(io_in));
	// compare and count
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one write strobe, then a quiet cycle
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_req_i.wr_en = 1'b1;
		reg_req_i.addr = a;
		reg_req_i.wdata = d;
		@(negedge clk_i);
		reg_req_i.wr_en = 1'b0;
		@(negedge clk_i);
	endtask
	// read data is due one cycle after the address
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		reg_req_i.addr = a;
		@(negedge clk_i);
		check({24'h0, reg_rdata_o}, {24'h0, exp});
	endtask
	// verdict and end of run
	task automatic complete_run;
		$display("errors %0d checks %0d", errors, checks);
		if (errors == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// watchdog
	initial begin
		#20us;
		errors++;
		complete_run();
	end
	// main sequence
	initial begin
		repeat (10) @(negedge clk_i);
		check(io_drive_o, 32'h0000ffff);
		resetn_i = 1'b1;
		@(negedge clk_i);
		rd(plt_pkg::OFS_A_TWO_INPUT, plt_pkg::RST_A_TWO_INPUT);
		rd(plt_pkg::OFS_B_THREE_INPUT, plt_pkg::RST_B_THREE_INPUT);
		wr(8'h23, TAB_A);
		wr(8'h24, TAB_B);
		wr(8'h25, 8'hff);
		rd(8'h23, TAB_A);
		rd(8'h24, TAB_B);
		rd(8'h25, 8'h00);
		// decode on all three lines, selectors walked with no host access
		mode_ahi = 2'h1;
		mode_alo = 2'h1;
		mode_bhi = 2'h2;
		for (int s = 0; s < 8; s++) begin
			ext_val = {1'b0, 3'(s), 6'h0, 2'(s), 2'h0, 2'(s)};
			@(negedge clk_i);
			check({io_drive_o.out[15], io_drive_o.out[6], io_drive_o.out[2],
				io_drive_o.oe_n[15], io_drive_o.oe_n[6], io_drive_o.oe_n[2]},
				{TAB_B[s], TAB_A[4 + s % 4], TAB_A[s % 4], 3'b000});
		end
		// other modes leave the lines to normal gpio
		ext_val = 16'h1012;
		for (int m = 0; m < 3; m++) begin
			mode_ahi = (m == 0) ? 2'h0 : 2'(m + 1);
			mode_alo = mode_ahi;
			mode_bhi = (m == 2) ? 2'h3 : 2'(m);
			@(negedge clk_i);
			check(io_drive_o, gpio);
		end
		// a reset in mid run clears both tables and the pin drive
		resetn_i = 1'b0;
		@(negedge clk_i);
		check(io_drive_o, 32'h0000ffff);
		resetn_i = 1'b1;
		rd(plt_pkg::OFS_A_TWO_INPUT, plt_pkg::RST_A_TWO_INPUT);
		rd(plt_pkg::OFS_B_THREE_INPUT, plt_pkg::RST_B_THREE_INPUT);
		mode_ahi = 2'h1;
		mode_alo = 2'h1;
		mode_bhi = 2'h2;
		ext_val = 16'h0000;
		@(negedge clk_i);
		check({io_drive_o.out[15], io_drive_o.out[6], io_drive_o.out[2]}, 3'b000);
		complete_run();
	end
endmodule
`default_nettype wire
